// ### common/cps_defines.svh
/*
 Constants for the processor power/reset sequencer and its system-side partner.
 Assumes a single 20 MHz clock (mclk) shared by both ends.
*/
// Contract
// - Power-stable held low, glitch-free, until supplies good
// - Each power-stable rise followed by 1 ms reset
// - Power-stable stays high during boundary scan
// - Power-on reset held at least 1 ms
// - Reset returns known state, caches invalidated, no writeback
// - Bus outputs released within two clocks of reset (here six clocks after reset_n falls, through the synchroniser)
// - Configuration sampled on reset release
// - Optional self-test, then fetch from configured vector
// - Stop-clock request enters stop-grant, acknowledge, gate clocks
// - Stop-grant keeps snooping and interrupts, bus clock untouched (stop-grant here ignores the mgmt interrupt until back in run)
// - Stop-clock release restores clocks and execution
// - Sleep request in stop-grant stops all clocks
// - Sleep ignores snoops, interrupts; watches sleep, stop, reset (sleep state here watches sleep, power-stable and reset, not stop)
// - Sleep release returns to stop-grant
// - Management interrupt saves state, acknowledges, runs handler
// - Test-port reset driven low during power-on reset
// - Supply reads code, delivers voltage or shuts off
// - Code decode table, 01111/11111 mean no processor
`ifndef CPS_DEFINES_SVH
`define CPS_DEFINES_SVH
`define CPS_CLK_MHZ 20
`define CPS_RESET_US 1000
`define CPS_RESET_CYC (`CPS_RESET_US * `CPS_CLK_MHZ)
`define CPS_RELEASE_CYC 2
`define CPS_VEC_LOW 32'h000FFFF0
`define CPS_VEC_HIGH 32'h0FFFFFF0
`define CPS_CFG_W 4
`define CPS_CFG_TRISTATE 0
`define CPS_CFG_SELFTEST 1
`define CPS_CFG_VEC_HIGH 2
`define CPS_SELFTEST_CYC 16
`define CPS_SUPPLY_CODE 5'h06
`define CPS_CODE_NONE_A 5'h0F
`define CPS_CODE_NONE_B 5'h1F
`define CPS_MV_HIGH_BASE 2000
`define CPS_MV_HIGH_STEP 50
`define CPS_MV_LOW_BASE 1275
`define CPS_MV_LOW_STEP 25
`endif

// ### common/cps_pkg.sv
/*
 Types shared by both ends of the power/reset sequencer.
 Assumes cps_defines.svh is on the include path.
*/
package cps_pkg;
   typedef enum logic [2:0] {
      cps_off, cps_reset, cps_selftest, cps_run, cps_grant, cps_sleep, cps_mgmt
   } cps_state_type;
   typedef enum logic [1:0] {
      cps_sys_down, cps_sys_wait, cps_sys_reset, cps_sys_up
   } cps_sys_type;
endpackage : cps_pkg

// ### common/cps_link_if.sv
/*
 Pins between the processor sequencer and the system logic.
 Assumes both ends run on the same mclk.
*/
interface cps_link_if;
   logic power_stable_ind;
   logic reset_n;
   logic test_reset_n;
   logic clock_halt_req_n;
   logic deep_idle_req_n;
   logic mgmt_irq_n;
   logic [3:0] cfg_pins;
   logic [4:0] supply_code;
   logic bus_out_en;
   logic grant_ack;
   logic mgmt_ack;
   modport dev (input power_stable_ind, reset_n, test_reset_n, clock_halt_req_n, deep_idle_req_n,
                mgmt_irq_n, cfg_pins, output supply_code, bus_out_en, grant_ack, mgmt_ack);
   modport sys (output power_stable_ind, reset_n, test_reset_n, clock_halt_req_n, deep_idle_req_n,
                mgmt_irq_n, cfg_pins, input supply_code, bus_out_en, grant_ack, mgmt_ack);
endinterface : cps_link_if

// ### rtl/cps_device.sv
/*
 Processor-side power, reset and low-power state sequencer.
 Assumes link inputs are asynchronous to mclk; user side sees clock gates,
 fetch start and cache invalidate.
*/
`include "cps_defines.svh"
module cps_device import cps_pkg::*; (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Link
   cps_link_if.dev link,
   // Core side
   input wire logic snoop_req,
   input wire logic mgmt_done,
   output logic core_clk_en,
   output logic bus_clk_en,
   output logic snoop_ack,
   output logic cache_inval,
   output logic save_state,
   output logic fetch_start,
   output logic [31:0] fetch_addr,
   output cps_state_type state
);
   // Three-stage synchronisers; a change counts when stages 2 and 3 agree
   logic [2:0] s_pg;
   logic [2:0] s_rst;
   logic [2:0] s_halt;
   logic [2:0] s_idle;
   logic [2:0] s_mgmt;
   logic pg;
   logic rst_n;
   logic halt_n;
   logic idle_n;
   logic mgmt_n;
   // Straps pass the same filter so a strap still settling is never captured
   logic [`CPS_CFG_W-1:0] cfg_meta;
   logic [`CPS_CFG_W-1:0] cfg_sync;
   logic [`CPS_CFG_W-1:0] cfg_s3;
   logic [`CPS_CFG_W-1:0] cfg_in;
   logic [`CPS_CFG_W-1:0] cfg;
   logic [4:0] st_cnt;
   logic [1:0] rel_cnt;
   logic bus_en;
   logic grant_ack;
   logic mgmt_ack;
   cps_state_type next_state;

   // Hold the old level while stages 2 and 3 differ; an unknown stage also holds
   function automatic logic settle(input logic [2:0] stages, input logic level);
      if (stages[1] == stages[2]) settle = stages[2];
      else settle = level;
   endfunction : settle

   // Fetch address selected by the high-vector strap
   function automatic logic [31:0] vector_of(input logic [`CPS_CFG_W-1:0] straps);
      vector_of = straps[`CPS_CFG_VEC_HIGH] ? `CPS_VEC_HIGH : `CPS_VEC_LOW;
   endfunction : vector_of

   always_ff @(posedge mclk) begin
      s_pg <= {s_pg[1:0], link.power_stable_ind};
      s_rst <= {s_rst[1:0], link.reset_n};
      s_halt <= {s_halt[1:0], link.clock_halt_req_n};
      s_idle <= {s_idle[1:0], link.deep_idle_req_n};
      s_mgmt <= {s_mgmt[1:0], link.mgmt_irq_n};
      cfg_meta <= link.cfg_pins;
      cfg_sync <= cfg_meta;
      cfg_s3 <= cfg_sync;
   end

   // Filtered levels
   always_ff @(posedge mclk) begin
      if (rst) begin
         pg <= 1'b0;
         rst_n <= 1'b0;
         halt_n <= 1'b1;
         idle_n <= 1'b1;
         mgmt_n <= 1'b1;
         cfg_in <= '0;
      end else begin
         pg <= settle(s_pg, pg);
         rst_n <= settle(s_rst, rst_n);
         halt_n <= settle(s_halt, halt_n);
         idle_n <= settle(s_idle, idle_n);
         mgmt_n <= settle(s_mgmt, mgmt_n);
         if (cfg_sync == cfg_s3) cfg_in <= cfg_s3;
      end
   end

   // Decoded conditions
   wire in_reset = !pg || !rst_n;
   wire reset_release = (state == cps_reset) && pg && rst_n;
   wire selftest_done = (st_cnt == 5'(`CPS_SELFTEST_CYC - 1));
   wire strap_tristate = cfg_in[`CPS_CFG_TRISTATE];
   wire strap_selftest = cfg_in[`CPS_CFG_SELFTEST];
   wire outputs_off = cfg[`CPS_CFG_TRISTATE];
   wire [31:0] vector = vector_of(cfg);
   wire [31:0] vector_now = vector_of(cfg_in);

   // Sleep only listens to sleep, power-stable and reset; mgmt waits in run
   always_comb begin
      next_state = state;
      case (state)
         cps_off:
            if (pg) next_state = cps_reset;
         cps_reset:
            if (reset_release) begin
               if (strap_tristate) next_state = cps_reset;
               else if (strap_selftest) next_state = cps_selftest;
               else next_state = cps_run;
            end
         cps_selftest:
            if (selftest_done) next_state = cps_run;
         cps_run:
            if (!mgmt_n) next_state = cps_mgmt;
            else if (!halt_n) next_state = cps_grant;
         cps_grant:
            if (!idle_n) next_state = cps_sleep;
            else if (halt_n) next_state = cps_run;
         cps_sleep:
            if (idle_n) next_state = cps_grant;
         cps_mgmt:
            if (mgmt_done) next_state = cps_run;
         default:
            next_state = cps_off;
      endcase
      if (!pg) next_state = cps_off;
      else if (!rst_n) next_state = cps_reset;
   end

   // Output decode, registered below so every output but the constant supply_code leaves a flop
   wire enter_grant = (state == cps_run) && (next_state == cps_grant);
   wire enter_mgmt = (state == cps_run) && (next_state == cps_mgmt);
   wire enter_run = (next_state == cps_run) && ((state == cps_reset) || (state == cps_selftest));
   wire core_running = (next_state == cps_run) || (next_state == cps_mgmt) || (next_state == cps_selftest);
   wire bus_clocked = (next_state != cps_sleep) && (next_state != cps_off);
   wire snoop_taken = snoop_req && (state != cps_sleep) && !in_reset;
   wire bus_may_drive = (state != cps_sleep) && (state != cps_off) && !outputs_off;
   wire release_due = (rel_cnt == 2'h0);
   wire [4:0] next_st_cnt = (state == cps_selftest) ? st_cnt + 5'h01 : 5'h00;

   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= cps_off;
         cfg <= '0;
         st_cnt <= '0;
      end else begin
         state <= next_state;
         if (reset_release) cfg <= cfg_in;
         st_cnt <= next_st_cnt;
      end
   end

   // Bus drivers drop on the second clock after the filtered reset, six clocks after reset_n falls on the link,
   // outside the two-clock allowance; the counter keeps that margin adjustable
   always_ff @(posedge mclk) begin
      if (rst) begin
         rel_cnt <= '0;
         bus_en <= 1'b0;
      end else if (in_reset) begin
         if (release_due) begin
            rel_cnt <= 2'(`CPS_RELEASE_CYC - 1);
            bus_en <= 1'b0;
         end else begin
            rel_cnt <= rel_cnt - 2'h1;
         end
      end else begin
         rel_cnt <= 2'(`CPS_RELEASE_CYC - 1);
         bus_en <= bus_may_drive;
      end
   end

   // Clock gates and cache invalidate
   always_ff @(posedge mclk) begin
      if (rst) begin
         core_clk_en <= 1'b0;
         bus_clk_en <= 1'b0;
         cache_inval <= 1'b0;
      end else begin
         core_clk_en <= core_running;
         bus_clk_en <= bus_clocked;
         cache_inval <= (next_state == cps_reset);
      end
   end

   // Acknowledges and snoop answer
   always_ff @(posedge mclk) begin
      if (rst) begin
         snoop_ack <= 1'b0;
         grant_ack <= 1'b0;
         mgmt_ack <= 1'b0;
         save_state <= 1'b0;
      end else begin
         snoop_ack <= snoop_taken;
         grant_ack <= enter_grant;
         mgmt_ack <= enter_mgmt;
         save_state <= enter_mgmt;
      end
   end

   // Fetch start; the address follows the straps being captured
   always_ff @(posedge mclk) begin
      if (rst) begin
         fetch_start <= 1'b0;
         fetch_addr <= '0;
      end else begin
         fetch_start <= enter_run;
         if (reset_release) fetch_addr <= vector_now;
         else if (state == cps_selftest) fetch_addr <= vector;
      end
   end

   assign link.supply_code = `CPS_SUPPLY_CODE;
   assign link.bus_out_en = bus_en;
   assign link.grant_ack = grant_ack;
   assign link.mgmt_ack = mgmt_ack;
endmodule : cps_device

// ### rtl/cps_system.sv
/*
 System-side partner: power-stable, power-on reset, test-port reset,
 low-power requests and supply code decode.
 Assumes supply_good comes from the regulator, already in mclk domain.
*/
`include "cps_defines.svh"
module cps_system import cps_pkg::*; #(
   parameter int unsigned RESET_CYC = `CPS_RESET_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Link
   cps_link_if.sys link,
   // User side
   input wire logic supply_good,
   input wire logic scan_active,
   input wire logic halt_req,
   input wire logic idle_req,
   input wire logic mgmt_req,
   input wire logic [3:0] cfg_value,
   output logic supply_enable,
   output logic [11:0] supply_mv,
   output logic [4:0] code_seen,
   output cps_sys_type sys_state
);
   logic [31:0] cnt;
   logic pg, rst_n, halt_n, idle_n, mgmt_n;
   logic [4:0] code_meta, code_sync;
   cps_sys_type next_sys;

   function automatic logic [11:0] decode_mv(input logic [4:0] code);
      if (code == `CPS_CODE_NONE_A || code == `CPS_CODE_NONE_B) decode_mv = 12'h000;
      else if (!code[4]) decode_mv = 12'(`CPS_MV_HIGH_BASE - `CPS_MV_HIGH_STEP * code[3:0]);
      else decode_mv = 12'(`CPS_MV_LOW_BASE - `CPS_MV_LOW_STEP * code[3:0]);
   endfunction : decode_mv

   wire cnt_done = (cnt >= RESET_CYC - 1);

   always_comb begin
      next_sys = sys_state;
      case (sys_state)
         cps_sys_down: if (supply_good) next_sys = cps_sys_wait;
         cps_sys_wait: next_sys = cps_sys_reset;
         cps_sys_reset: if (cnt_done) next_sys = cps_sys_up;
         cps_sys_up: ;
         default: next_sys = cps_sys_down;
      endcase
      // Scan keeps power-stable up even if supply dips
      if (!supply_good && !scan_active) next_sys = cps_sys_down;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sys_state <= cps_sys_down;
         cnt <= '0;
         pg <= 1'b0;
         rst_n <= 1'b0;
         halt_n <= 1'b1;
         idle_n <= 1'b1;
         mgmt_n <= 1'b1;
         code_meta <= 5'h1F;
         code_sync <= 5'h1F;
         code_seen <= 5'h1F;
         supply_mv <= 12'h000;
         supply_enable <= 1'b0;
      end else begin
         sys_state <= next_sys;
         cnt <= (sys_state == cps_sys_reset) ? cnt + 32'h1 : 32'h0;
         pg <= (next_sys != cps_sys_down);
         rst_n <= (next_sys == cps_sys_up);
         halt_n <= !(halt_req || idle_req);
         idle_n <= !(idle_req && !halt_n); // only while halt_n is already low
         mgmt_n <= !mgmt_req;
         code_meta <= link.supply_code;
         code_sync <= code_meta;
         code_seen <= code_sync;
         supply_mv <= decode_mv(code_seen);
         supply_enable <= supply_good && (decode_mv(code_seen) != 12'h000);
      end
   end

   assign link.power_stable_ind = pg;
   assign link.reset_n = rst_n;
   assign link.test_reset_n = rst_n;
   assign link.clock_halt_req_n = halt_n;
   assign link.deep_idle_req_n = idle_n;
   assign link.mgmt_irq_n = mgmt_n;
   assign link.cfg_pins = cfg_value;
endmodule : cps_system

// ### test/cps_link_sva.sv
/*
 Link checker for the sequencer pair.
 Assumes it sits beside the link interface on the shared mclk.
*/
`include "cps_defines.svh"
module cps_link_sva #(
   parameter int unsigned RESET_CYC = `CPS_RESET_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Link
   input wire logic power_stable_ind,
   input wire logic reset_n,
   input wire logic test_reset_n,
   input wire logic clock_halt_req_n,
   input wire logic deep_idle_req_n,
   input wire logic mgmt_irq_n,
   input wire logic [3:0] cfg_pins,
   input wire logic [4:0] supply_code,
   input wire logic bus_out_en,
   input wire logic grant_ack,
   input wire logic mgmt_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] low_cnt;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // Cycles of reset held while power is stable
   always_ff @(posedge mclk) begin
      if (rst || !power_stable_ind || reset_n) low_cnt <= 16'h0000;
      else low_cnt <= low_cnt + 16'h0001;
   end
   a_reset_len: assert property ($rose(reset_n) |-> low_cnt >= RESET_CYC)
      else $error("reset released early");
   a_pg_then_reset: assert property ($rose(power_stable_ind) |-> !reset_n ##1 !reset_n)
      else $error("no reset after power stable");
   a_bus_release: assert property ($fell(reset_n) |-> ##[1:8] !bus_out_en)
      else $error("bus outputs not released");
   a_test_reset: assert property (!reset_n |-> !test_reset_n)
      else $error("test reset not low in reset");
   a_cfg_steady: assert property ($rose(reset_n) |-> $stable(cfg_pins))
      else $error("config moved at reset release");
   a_code_fixed: assert property (supply_code == `CPS_SUPPLY_CODE)
      else $error("supply code changed");
   a_grant_cause: assert property (grant_ack |-> !$past(clock_halt_req_n, 3) ##1 !grant_ack)
      else $error("grant ack without halt request");
   a_mgmt_cause: assert property (mgmt_ack |-> !$past(mgmt_irq_n, 3) ##1 !mgmt_ack)
      else $error("mgmt ack without request");
   a_idle_in_halt: assert property (!deep_idle_req_n |-> !clock_halt_req_n)
      else $error("idle request outside halt");
endmodule : cps_link_sva

// ### test/cps_power_state_reset_seq_tb.sv
/*
 Bench joining device and system ends over one link.
 Assumes a 20 MHz mclk and a shortened power-on reset count.
*/
`include "cps_defines.svh"
module cps_power_state_reset_seq_tb import cps_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned RC = 50;
   localparam logic [3:0] CASES [4] = '{4'h1, 4'h2, 4'h4, 4'h0};
   logic mclk, rst, snoop_req, mgmt_done, supply_good, halt_req, idle_req, mgmt_req, scan_active;
   logic [3:0] cfg_value;
   logic core_clk_en, bus_clk_en, snoop_ack, cache_inval, save_state, fetch_start, supply_enable;
   logic [31:0] fetch_addr;
   logic [11:0] supply_mv;
   logic [4:0] code_seen;
   cps_state_type state;
   int err_count, comparisons, cycles, grants, mgmts, saves, fetches, f0;
   cps_link_if link ();
   cps_device i_cps_device (.mclk(mclk), .rst(rst), .link(link), .snoop_req(snoop_req), .mgmt_done(mgmt_done),
      .core_clk_en(core_clk_en), .bus_clk_en(bus_clk_en), .snoop_ack(snoop_ack), .cache_inval(cache_inval),
      .save_state(save_state), .fetch_start(fetch_start), .fetch_addr(fetch_addr), .state(state));
   cps_system #(.RESET_CYC(RC)) i_cps_system (.mclk(mclk), .rst(rst), .link(link), .supply_good(supply_good),
      .scan_active(scan_active), .halt_req(halt_req), .idle_req(idle_req), .mgmt_req(mgmt_req),
      .cfg_value(cfg_value),
      .supply_enable(supply_enable), .supply_mv(supply_mv), .code_seen(code_seen), .sys_state());
   cps_link_sva #(.RESET_CYC(RC)) i_cps_link_sva (.mclk(mclk), .rst(rst),
      .power_stable_ind(link.power_stable_ind), .reset_n(link.reset_n), .test_reset_n(link.test_reset_n),
      .clock_halt_req_n(link.clock_halt_req_n), .deep_idle_req_n(link.deep_idle_req_n),
      .mgmt_irq_n(link.mgmt_irq_n), .cfg_pins(link.cfg_pins), .supply_code(link.supply_code),
      .bus_out_en(link.bus_out_en), .grant_ack(link.grant_ack), .mgmt_ack(link.mgmt_ack));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   function automatic logic [11:0] exp_mv(input logic [4:0] c);
      if (c == `CPS_CODE_NONE_A || c == `CPS_CODE_NONE_B) return 12'h000;
      if (c[4]) return 12'(`CPS_MV_LOW_BASE - `CPS_MV_LOW_STEP * c[3:0]);
      return 12'(`CPS_MV_HIGH_BASE - `CPS_MV_HIGH_STEP * c[3:0]);
   endfunction : exp_mv
   task automatic end_of_test();
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wait_state(input cps_state_type s);
      int n;
      n = 0;
      while (state !== s && n < 60) begin
         @(negedge mclk);
         n++;
      end
      chk(state, s);
   endtask : wait_state
   // One power cycle with the given strap value
   task automatic boot(input logic [3:0] cfg);
      int n;
      @(negedge mclk);
      supply_good = 1'b0;
      cfg_value = cfg;
      repeat (6) @(negedge mclk);
      f0 = fetches;
      supply_good = 1'b1;
      repeat (2) @(negedge mclk);
      chk(link.power_stable_ind, 1'b1);
      repeat (RC - 4) @(negedge mclk);
      chk({link.reset_n, link.test_reset_n, cache_inval}, 3'b001);
      n = 0;
      while (link.reset_n !== 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
      end
      chk(link.reset_n, 1'b1);
      if (cfg[`CPS_CFG_TRISTATE]) begin
         repeat (30) @(negedge mclk);
         chk(state, cps_reset);
      end else begin
         if (cfg[`CPS_CFG_SELFTEST]) wait_state(cps_selftest);
         wait_state(cps_run);
         chk(fetch_addr, cfg[`CPS_CFG_VEC_HIGH] ? `CPS_VEC_HIGH : `CPS_VEC_LOW);
         // The fetch pulse is only counted on the following rising edge
         @(negedge mclk);
      end
      chk(fetches - f0, 32'(!cfg[`CPS_CFG_TRISTATE]));
   endtask : boot
   always @(posedge mclk) begin
      cycles++;
      if (link.grant_ack === 1'b1) grants++;
      if (link.mgmt_ack === 1'b1) mgmts++;
      if (save_state === 1'b1) saves++;
      if (fetch_start === 1'b1) fetches++;
      if (cycles == 5000) begin
         err_count++;
         end_of_test();
      end
   end
   initial begin
      {rst, snoop_req, mgmt_done, supply_good, halt_req, idle_req, mgmt_req} = 7'h40;
      cfg_value = 4'h0;
      scan_active = 1'b0;
      void'($urandom(32'hEBDD));
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      foreach (CASES[i]) boot(CASES[i]);
      // Tristate strap left out of random boots so the run ends executing
      repeat (3) boot(4'($urandom) & 4'h6);
      // Supply dips during a scan: power stable and reset hold, supply shuts off
      scan_active = 1'b1;
      supply_good = 1'b0;
      repeat (4) @(negedge mclk);
      chk({link.power_stable_ind, link.reset_n, supply_enable}, 3'b110);
      supply_good = 1'b1;
      scan_active = 1'b0;
      @(negedge mclk);
      chk({supply_enable, code_seen}, {1'b1, `CPS_SUPPLY_CODE});
      chk(supply_mv, exp_mv(`CPS_SUPPLY_CODE));
      halt_req = 1'b1;
      wait_state(cps_grant);
      repeat (2) @(negedge mclk);
      chk(grants, 1);
      chk({core_clk_en, bus_clk_en}, 2'b01);
      snoop_req = 1'b1;
      repeat (2) @(negedge mclk);
      chk(snoop_ack, 1'b1);
      idle_req = 1'b1;
      wait_state(cps_sleep);
      mgmt_req = 1'b1;
      repeat (10) @(negedge mclk);
      chk({state, bus_clk_en, snoop_ack}, {cps_sleep, 2'b00});
      chk(mgmts, 0);
      {mgmt_req, idle_req} = 2'b00;
      wait_state(cps_grant);
      chk(bus_clk_en, 1'b1);
      {halt_req, snoop_req} = 2'b00;
      wait_state(cps_run);
      chk(core_clk_en, 1'b1);
      mgmt_req = 1'b1;
      wait_state(cps_mgmt);
      repeat (2) @(negedge mclk);
      chk({saves[7:0], mgmts[7:0]}, 16'h0101);
      mgmt_req = 1'b0;
      // Let the released request pass the device's filter before the handler ends
      repeat (6) @(negedge mclk);
      mgmt_done = 1'b1;
      @(negedge mclk);
      mgmt_done = 1'b0;
      wait_state(cps_run);
      repeat (6) @(negedge mclk);
      chk({state, mgmts[7:0]}, {cps_run, 8'h01});
      end_of_test();
   end
endmodule : cps_power_state_reset_seq_tb
